/* design/etp_top.sv */
/*
 etp_top: line timing for extended panel types, counted in
 pixel clocks, set through an AXI4-Lite register slave.
 Assumes aclk at 100 MHz, one outstanding write and one read.
*/
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module etp_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pixel_clk,
    input wire logic [etp_pkg::ETP_AW-1:0] awaddr,
    input wire logic awvalid,
    output var logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output var logic wready,
    output var logic [1:0] bresp,
    output var logic bvalid,
    input wire logic bready,
    input wire logic [etp_pkg::ETP_AW-1:0] araddr,
    input wire logic arvalid,
    output var logic arready,
    output var logic [31:0] rdata,
    output var logic [1:0] rresp,
    output var logic rvalid,
    input wire logic rready,
    output var etp_pkg::etp_panel_t panel
);
    import etp_pkg::*;

    logic tick;
    logic [15:0] regs [ETP_NREG];
    logic [ETP_NREG-1:0] wsel;
    logic [ETP_NREG-1:0] rsel;
    logic aw_have_q;
    logic w_have_q;
    logic [ETP_AW-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;
    logic rd_stat;
    logic [31:0] rd_d;
    logic [9:0] h_q;
    logic [9:0] v_q;
    logic [9:0] last;
    logic [5:0] mode;
    logic is_alpha;
    logic is_refl;
    logic is_t2;
    logic act;
    logic [10:0] hn;
    logic [10:0] hd;
    logic [10:0] start_w;
    logic [10:0] load_w;
    logic [10:0] load_at;
    logic [10:0] gate_at;
    logic [10:0] com_at;
    logic [10:0] clr_w;
    logic [10:0] latch_end;
    logic [10:0] sv2_at;
    logic [10:0] flip_at;
    logic [10:0] amp_w;
    logic [10:0] hold;
    logic [10:0] setup;
    logic sv2_q;
    logic sv2_d;
    logic run_q;
    logic run_d;
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    etp_panel_t panel_q;
    etp_panel_t pd;

    etp_pix_tick etp_pix_tick_i
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .pixel_clk(pixel_clk),
        .tick(tick)
    );

    genvar k;
    generate
        for (k = 0; k < ETP_NREG; k++)
        begin : g_reg
            logic [15:0] r_q;
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    r_q <= ETP_RST[k];
                else if (wr_go && wsel[k])
                begin
                    if (wstrb_q[0])
                        r_q[7:0] <= wdata_q[7:0] & ETP_MASK[k][7:0];
                    if (wstrb_q[1])
                        r_q[15:8] <= wdata_q[15:8] & ETP_MASK[k][15:8];
                end
            end
            assign regs[k] = r_q;
            assign wsel[k] = waddr_q == {ETP_IDX[k], 2'b00};
            assign rsel[k] = araddr == {ETP_IDX[k], 2'b00};
        end
    endgenerate

    assign wr_go = aw_have_q && w_have_q && !bvalid;
    assign rd_stat = araddr == {ETP_STAT_IDX, 2'b00};

    // write channels, taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= ETP_OKAY;
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_have_q <= 1'b1;
                awready <= 1'b0;
                waddr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_have_q <= 1'b1;
                wready <= 1'b0;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_go)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (|wsel) ? ETP_OKAY : ETP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_comb
    begin
        rd_d = '0;
        for (int i = 0; i < ETP_NREG; i++)
            if (rsel[i])
                rd_d[15:0] = regs[i];
        if (rd_stat)
            rd_d = {6'h00, v_q, 6'h00, h_q};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= ETP_OKAY;
        end
        else
        begin
            if (arvalid && arready)
            begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_d;
                rresp <= (|rsel || rd_stat) ? ETP_OKAY : ETP_SLVERR;
            end
            if (rvalid && rready)
            begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    assign mode = regs[S_PSEL][ETP_MODE_LSB +: 6];
    assign is_alpha = mode == ETP_MODE_ALPHA;
    assign is_refl = mode == ETP_MODE_REFL;
    assign is_t2 = mode == ETP_MODE_T2;
    // alpha total is field plus one
    assign last = is_alpha ? regs[S_ATOT][9:0] : regs[S_LTOT][9:0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            h_q <= '0;
            v_q <= '0;
        end
        else if (tick)
        begin
            if (h_q >= last)
            begin
                h_q <= '0;
                v_q <= (v_q >= regs[S_VTOT][9:0]) ? '0 : v_q + 10'h001;
            end
            else
                h_q <= h_q + 10'h001;
        end
    end

    assign hn = {1'b0, h_q};
    assign hd = {1'b0, regs[S_HDISP][9:0]};
    // start width is field minus one
    assign start_w = 11'(regs[S_AWID][ETP_STW_LSB +: 3]) - 11'h001;
    // load width is field minus one
    assign load_w = 11'(regs[S_AWID][ETP_LDW_LSB +: 3]) - 11'h001;
    assign load_at = start_w + hd + {1'b0, regs[S_ALOAD][9:0]} + ETP_LEAD;
    // gate clock leads the load edge
    assign gate_at = load_at - {1'b0, regs[S_AGATE][9:0]};
    // common signal leads the load edge
    assign com_at = load_at - {1'b0, regs[S_ACOM][9:0]};
    assign clr_w = {2'b00, regs[S_CLRW][8:0]};
    assign latch_end = hd + ETP_LATCH_W;
    assign sv2_at = latch_end + {3'b000, regs[S_SV2R][7:0]};
    assign flip_at = hd - {6'h00, regs[S_FLIP][4:0]};
    // phases run end lines past display
    assign act = {1'b0, v_q} < {1'b0, regs[S_VDISP][9:0]}
        + {8'h00, regs[S_SVEND][2:0]};
    assign amp_w = {2'b00, ETP_AMP_W[regs[S_T2CFG][ETP_AMP_LSB +: 3]]};
    assign hold = {6'h00, ETP_GATE_DLY[regs[S_T2CFG][ETP_HOLD_LSB +: 2]]};
    assign setup = {6'h00,
        ETP_GATE_DLY[regs[S_T2CFG][ETP_SETUP_LSB +: 2]]};

    always_comb
    begin
        sv2_d = sv2_q;
        run_d = run_q;
        cnt_d = cnt_q + 7'h01;
        if (h_q == '0)
        begin
            sv2_d = 1'b0;
            run_d = 1'b0;
        end
        else if (hn == sv2_at)
        begin
            sv2_d = 1'b1;
            run_d = 1'b1;
            cnt_d = 7'h01;
        end
        else if (run_q && cnt_q == regs[S_SV2T][6:0])
        begin
            sv2_d = !sv2_q;
            cnt_d = 7'h01;
        end
    end

    always_comb
    begin
        pd = '0;
        case (mode)
            // alpha pins only in alpha mode
            ETP_MODE_ALPHA:
            begin
                pd.horizontal_start_pulse = hn < start_w;
                pd.line_load_pulse = hn >= load_at
                    && hn < load_at + load_w;
                pd.gate_shift_clock = panel_q.gate_shift_clock
                    ^ (hn == gate_at);
                pd.common_electrode_toggle =
                    panel_q.common_electrode_toggle ^ (hn == com_at);
            end
            // reflective pins only in reflective mode
            ETP_MODE_REFL:
            begin
                pd.line_latch_pulse = hn >= hd && hn < latch_end;
                pd.line_clear_pulse = hn < clr_w;
                pd.save_phase_one = act
                    && hn >= clr_w + {5'h00, regs[S_SV1][5:0]};
                pd.save_phase_two = act && sv2_d;
                pd.save_phase_three = act && hn >= latch_end
                    && hn < latch_end + {4'h0, regs[S_SV3W][6:0]};
                pd.polarity_flip_signal = panel_q.polarity_flip_signal
                    ^ (hn == flip_at);
            end
            // type-two pins only in type-two mode
            ETP_MODE_T2:
            begin
                pd.line_strobe_output = hn >= hd && hn < latch_end;
                pd.gate_clock_pin = hn >= hd - setup && hn < hd + hold;
                pd.amplifier_drive_pulse = hn >= hd && hn < hd + amp_w;
            end
            default:
                pd = '0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            panel_q <= '0;
            sv2_q <= 1'b0;
            run_q <= 1'b0;
            cnt_q <= '0;
        end
        else if (tick)
        begin
            panel_q <= pd;
            sv2_q <= sv2_d;
            run_q <= run_d;
            cnt_q <= cnt_d;
        end
    end

    assign panel = panel_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_total_wrap: assert property (
        tick && is_alpha && h_q == regs[S_ATOT][9:0] |=> h_q == '0
    ) else $error("alpha line did not wrap at total");
    a_alpha_gated: assert property (
        tick && !is_alpha |=> !panel.horizontal_start_pulse
            && !panel.line_load_pulse
    ) else $error("alpha pins active outside alpha mode");
    a_load_rise: assert property (
        tick && is_alpha && hn == load_at && load_w != '0
            |=> $rose(panel.line_load_pulse)
    ) else $error("load pulse did not rise at position");
    a_gate_toggle: assert property (
        tick && is_alpha && hn == gate_at
            |=> panel.gate_shift_clock != $past(panel.gate_shift_clock)
    ) else $error("gate clock did not toggle");
    a_com_toggle: assert property (
        tick && is_alpha && hn == com_at |=> $changed(
            panel.common_electrode_toggle)
    ) else $error("common signal did not toggle");
    a_start_end: assert property (
        tick && is_alpha && hn == start_w
            |=> !panel.horizontal_start_pulse
    ) else $error("start pulse too long");
    a_clear_end: assert property (
        tick && is_refl && hn == clr_w |=> !panel.line_clear_pulse
    ) else $error("clear pulse too long");
    a_phase_two: assert property (
        tick && is_refl && act && hn == sv2_at
            |=> panel.save_phase_two
    ) else $error("phase two did not rise");
    a_phase_end: assert property (
        tick && is_refl && !act |=> !panel.save_phase_one
            && !panel.save_phase_three
    ) else $error("save phase outside active lines");
    a_flip_toggle: assert property (
        tick && is_refl && hn == flip_at
            |=> $changed(panel.polarity_flip_signal)
    ) else $error("flip did not toggle");
    a_amp_end: assert property (
        tick && is_t2 && hn == hd + amp_w
            |=> !panel.amplifier_drive_pulse
    ) else $error("amplifier pulse too long");
    a_hold_fall: assert property (
        tick && is_t2 && hn == hd + hold |=> !panel.gate_clock_pin
    ) else $error("gate clock held too long");
    a_bad_write: assert property (
        wr_go && !(|wsel) |=> bvalid && bresp == ETP_SLVERR
    ) else $error("unmapped write not refused");
    a_read_answer: assert property (
        arvalid && arready |=> rvalid ##0 !arready [*1]
    ) else $error("read not answered next cycle");

    c_alpha_line: cover property (tick && is_alpha && h_q == '0);
    c_refl_phase: cover property ($rose(panel.save_phase_two));
    c_t2_amp: cover property ($fell(panel.amplifier_drive_pulse));
    c_write_done: cover property (bvalid && bready);
endmodule
`default_nettype wire

/* shared/etp_pkg.sv */
/*
 etp_pkg: register map, field layout, mode codes, tables and
 the panel pin bundle of the extended panel timing block.
 Assumes a 32-bit AXI4-Lite master and a sampled pixel clock.
*/
// How it works
// - alpha line total is field plus one
// - alpha fields act only in alpha mode
// - load pulse rises after start, display, field, 8
// - gate clock toggles lead clocks before load
// - common signal toggles lead clocks before load
// - load pulse width is field minus one
// - start pulse width is field minus one
// - reflective fields act only in reflective mode
// - clear pulse lasts its width field
// - phase one rises after clear falls
// - phase two first rises after latch falls
// - phase two holds each level toggle width
// - phase three lasts its width field
// - flip toggles field clocks before latch rise
// - save phases continue end-field lines past display
// - amplifier width chosen by 3-bit code
// - type-two fields act only in type-two mode
// - hold code sets strobe rise to gate fall
// - setup code sets gate rise to strobe
package etp_pkg;
    localparam int ETP_AW = 12;
    localparam int ETP_NREG = 19;
    localparam logic [9:0] ETP_STAT_IDX = 10'h035;
    localparam logic [1:0] ETP_OKAY = 2'h0;
    localparam logic [1:0] ETP_SLVERR = 2'h2;
    localparam int S_ATOT = 0;
    localparam int S_ALOAD = 1;
    localparam int S_AGATE = 2;
    localparam int S_ACOM = 3;
    localparam int S_AWID = 4;
    localparam int S_CLRW = 6;
    localparam int S_SV1 = 7;
    localparam int S_SV2R = 8;
    localparam int S_SV2T = 9;
    localparam int S_SV3W = 10;
    localparam int S_FLIP = 11;
    localparam int S_SVEND = 12;
    localparam int S_T2CFG = 13;
    localparam int S_PSEL = 14;
    localparam int S_HDISP = 15;
    localparam int S_LTOT = 16;
    localparam int S_VDISP = 17;
    localparam int S_VTOT = 18;
    // register index; byte address is four times it
    localparam logic [9:0] ETP_IDX [ETP_NREG] = '{
        10'h080, 10'h082, 10'h084, 10'h086, 10'h088, 10'h090,
        10'h092, 10'h094, 10'h096, 10'h098, 10'h09a, 10'h09e,
        10'h0a0, 10'h0a2, 10'h030, 10'h031, 10'h032, 10'h033,
        10'h034};
    localparam logic [15:0] ETP_MASK [ETP_NREG] = '{
        16'h03ff, 16'h03ff, 16'h03ff, 16'h03ff, 16'h0707, 16'h0002,
        16'h01ff, 16'h003f, 16'h00ff, 16'h007f, 16'h007f, 16'h001f,
        16'h0007, 16'h381b, 16'hfc00, 16'h03ff, 16'h03ff, 16'h03ff,
        16'h03ff};
    localparam logic [15:0] ETP_RST [ETP_NREG] = '{
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h012c, 16'h0032, 16'h0064, 16'h000a, 16'h0064, 16'h000a,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000};
    localparam int ETP_STW_LSB = 0;
    localparam int ETP_LDW_LSB = 8;
    localparam int ETP_MODE_LSB = 10;
    localparam int ETP_AMP_LSB = 11;
    localparam int ETP_HOLD_LSB = 3;
    localparam int ETP_SETUP_LSB = 0;
    localparam logic [5:0] ETP_MODE_ALPHA = 6'h30;
    localparam logic [5:0] ETP_MODE_REFL = 6'h01;
    localparam logic [5:0] ETP_MODE_T2 = 6'h03;
    localparam logic [10:0] ETP_LEAD = 11'h008;
    localparam logic [10:0] ETP_LATCH_W = 11'h004;
    localparam logic [8:0] ETP_AMP_W [8] = '{9'h014, 9'h028, 9'h050,
        9'h078, 9'h096, 9'h0be, 9'h0f0, 9'h10e};
    localparam logic [4:0] ETP_GATE_DLY [4] = '{5'h07, 5'h09, 5'h0c,
        5'h10};

    typedef struct packed {
        logic horizontal_start_pulse;
        logic line_load_pulse;
        logic gate_shift_clock;
        logic common_electrode_toggle;
        logic line_clear_pulse;
        logic save_phase_one;
        logic save_phase_two;
        logic save_phase_three;
        logic polarity_flip_signal;
        logic line_latch_pulse;
        logic amplifier_drive_pulse;
        logic gate_clock_pin;
        logic line_strobe_output;
    } etp_panel_t;
endpackage

/* design/etp_pix_tick.sv */
/*
 etp_pix_tick: brings the pixel clock into aclk and marks its
 rising edges with a one-cycle tick.
 Assumes the pixel clock is below half of aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module etp_pix_tick
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pixel_clk,
    output var logic tick
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
            tick <= 1'b0;
        end
        else
        begin
            meta_q <= pixel_clk;
            sync_q <= meta_q;
            last_q <= sync_q;
            tick <= sync_q && !last_q;
        end
    end
endmodule
`default_nettype wire

/* dv/etp_panel_model.sv */
/*
 etp_panel_model: passive panel that times one selected pin
 against a reference pin, in pixel clocks.
 Assumes eight aclk cycles per pixel clock.
*/
`timescale 1ns/1ps
`default_nettype none
module etp_panel_model
(
    input wire logic aclk,
    input wire etp_pkg::etp_panel_t panel,
    input wire logic [3:0] ref_pin,
    input wire logic [3:0] sel_pin,
    output var logic ev_valid,
    output var logic [3:0] ev_kind,
    output var logic [15:0] ev_val
);
    import etp_pkg::*;
    logic [12:0] pin_q = 13'h0;
    logic [12:0] pin_d;
    logic [31:0] now_q = 32'h0;
    logic [31:0] ref_at_q = 32'h0;
    logic [31:0] sel_at_q = 32'h0;
    logic r_up, r_dn, s_up, s_dn, same;

    function automatic logic [15:0] pix(input logic [31:0] t0, t1);
        return 16'((t1 - t0) >> 3);
    endfunction

    assign pin_d = panel;
    assign same = (ref_pin == sel_pin);
    assign r_up = pin_d[ref_pin] && !pin_q[ref_pin];
    assign r_dn = !pin_d[ref_pin] && pin_q[ref_pin] && !same;
    assign s_up = pin_d[sel_pin] && !pin_q[sel_pin];
    assign s_dn = !pin_d[sel_pin] && pin_q[sel_pin];

    // selected pin events win over reference events
    always_ff @(posedge aclk)
    begin
        pin_q <= pin_d;
        now_q <= now_q + 32'h1;
        ev_valid <= r_up || r_dn || (s_up && !same) || s_dn;
        if (r_up)
        begin
            ev_kind <= 4'd2;
            ev_val <= pix(ref_at_q, now_q);
            ref_at_q <= now_q;
        end
        if (r_dn)
        begin
            ev_kind <= 4'd3;
            ev_val <= pix(ref_at_q, now_q);
        end
        if (s_up)
            sel_at_q <= now_q;
        if (s_up && !same)
        begin
            ev_kind <= 4'd1;
            ev_val <= r_up ? 16'h0 : pix(ref_at_q, now_q);
        end
        if (s_dn)
        begin
            ev_kind <= 4'd0;
            ev_val <= pix(sel_at_q, now_q);
        end
    end
endmodule
`default_nettype wire

/* dv/test_extended_tft_panel_timing.sv */
/*
 test_extended_tft_panel_timing: self-checking bench for etp_top.
 Assumes etp_pkg, etp_top and etp_panel_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_extended_tft_panel_timing;
    import etp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic pixel_clk = 1'b0;
    logic [ETP_AW-1:0] awaddr = '0;
    logic [ETP_AW-1:0] araddr = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    etp_panel_t panel;
    logic [12:0] pins;
    logic [3:0] ref_pin = 4'h0;
    logic [3:0] sel_pin = 4'h0;
    logic ev_valid;
    logic [3:0] ev_kind;
    logic [15:0] ev_val;
    logic [19:0] q_bus [$];
    logic [19:0] q_pin [$];
    logic [31:0] seed = 32'h2820e1ea;
    int errors = 0;
    int samples_checked = 0;

    assign pins = panel;
    always #5 aclk = ~aclk;
    initial
    begin
        #3.3;
        forever #40 pixel_clk = ~pixel_clk;
    end

    etp_top etp_top_i
    (
        .aclk(aclk), .aresetn(aresetn), .pixel_clk(pixel_clk),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .panel(panel)
    );

    etp_panel_model etp_panel_model_i
    (
        .aclk(aclk), .panel(panel), .ref_pin(ref_pin), .sel_pin(sel_pin),
        .ev_valid(ev_valid), .ev_kind(ev_kind), .ev_val(ev_val)
    );

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic wr(input logic [9:0] idx, input logic [15:0] d,
        input logic [1:0] rs);
        @(posedge aclk);
        q_bus.push_back({2'b00, rs, 16'h0});
        awaddr <= {idx, 2'b00};
        wdata <= {16'h0, d};
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] idx, input logic [15:0] d,
        input logic [1:0] rs);
        @(posedge aclk);
        q_bus.push_back({2'b01, rs, d});
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask

    // pick pins, then wait for n whole reference rises
    task automatic arm(input logic [3:0] r, input logic [3:0] s, input int n);
        @(posedge aclk);
        ref_pin <= r;
        sel_pin <= s;
        repeat (n)
        begin
            do @(posedge aclk); while (pins[r] !== 1'b0);
            do @(posedge aclk); while (pins[r] !== 1'b1);
        end
        repeat (2) @(posedge aclk);
    endtask

    task automatic pe(input logic [3:0] k, input logic [15:0] v);
        q_pin.push_back({k, v});
    endtask

    task automatic drain();
        while (q_pin.size() > 0)
            @(posedge aclk);
    endtask

    // results are matched in order against the notes
    always @(posedge aclk)
    begin
        if (bvalid && bready)
            check({2'b00, bresp, 16'h0}, q_bus.pop_front());
        if (rvalid && rready)
            check({2'b01, rresp, rdata[15:0]}, q_bus.pop_front());
        if (ev_valid && q_pin.size() > 0)
            check({ev_kind, ev_val}, q_pin.pop_front());
    end

    // run should take about 37k cycles
    initial
    begin
        #900000;
        errors++;
        finish_test();
    end

    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 14; i++)
        begin
            rd(ETP_IDX[i], ETP_RST[i], ETP_OKAY);
            seed = lfsr(seed);
            wr(ETP_IDX[i], seed[15:0], ETP_OKAY);
            rd(ETP_IDX[i], seed[15:0] & ETP_MASK[i], ETP_OKAY);
        end
        // reserved places only read, status place written; all refused
        rd(10'h070, 16'h0, ETP_SLVERR);
        wr(ETP_STAT_IDX, 16'hffff, ETP_SLVERR);
        rd(10'h08e, 16'h0, ETP_SLVERR);
        // vertical total above display plus end
        wr(ETP_IDX[S_VDISP], 16'h03e0, ETP_OKAY);
        wr(ETP_IDX[S_VTOT], 16'h03ff, ETP_OKAY);
        wr(ETP_IDX[S_SVEND], 16'h0007, ETP_OKAY);
        wr(ETP_IDX[S_HDISP], 16'd20, ETP_OKAY);
        wr(ETP_IDX[S_LTOT], 16'd99, ETP_OKAY);
        wr(ETP_IDX[S_ATOT], 16'd99, ETP_OKAY);
        wr(ETP_IDX[S_ALOAD], 16'd10, ETP_OKAY);
        wr(ETP_IDX[S_AWID], 16'h0504, ETP_OKAY);
        wr(ETP_IDX[S_CLRW], 16'd9, ETP_OKAY);
        wr(ETP_IDX[S_SV1], 16'd5, ETP_OKAY);
        wr(ETP_IDX[S_SV2R], 16'd3, ETP_OKAY);
        wr(ETP_IDX[S_SV2T], 16'd6, ETP_OKAY);
        wr(ETP_IDX[S_SV3W], 16'd30, ETP_OKAY);
        wr(ETP_IDX[S_PSEL], {ETP_MODE_ALPHA, 10'h0}, ETP_OKAY);
        arm(4'd12, 4'd11, 2);
        pe(4'd3, 16'd3);
        pe(4'd1, 16'd41);
        pe(4'd0, 16'd4);
        pe(4'd2, 16'd100);
        drain();
        check({11'h0, pins[8:0]}, 20'h0);
        wr(ETP_IDX[S_PSEL], {ETP_MODE_REFL, 10'h0}, ETP_OKAY);
        arm(4'd3, 4'd5, 2);
        pe(4'd1, {5'h0, ETP_LATCH_W});
        pe(4'd0, 16'd30);
        pe(4'd2, 16'd100);
        drain();
        check({13'h0, pins[12:9], pins[2:0]}, 20'h0);
        arm(4'd3, 4'd6, 2);
        pe(4'd3, {5'h0, ETP_LATCH_W});
        pe(4'd1, 16'd7);
        pe(4'd0, 16'd6);
        drain();
        arm(4'd8, 4'd7, 2);
        pe(4'd3, 16'd9);
        pe(4'd1, 16'd14);
        pe(4'd0, 16'd86);
        drain();
        wr(ETP_IDX[S_HDISP], 16'd40, ETP_OKAY);
        wr(ETP_IDX[S_LTOT], 16'd319, ETP_OKAY);
        wr(ETP_IDX[S_PSEL], {ETP_MODE_T2, 10'h0}, ETP_OKAY);
        for (int k = 0; k < 8; k++)
        begin
            wr(ETP_IDX[S_T2CFG], {2'b00, 3'(k), 11'h0}, ETP_OKAY);
            arm(4'd2, 4'd2, 1);
            pe(4'd0, {7'h0, ETP_AMP_W[k]});
            drain();
        end
        check({10'h0, pins[12:3]}, 20'h0);
        for (int k = 0; k < 4; k++)
        begin
            wr(ETP_IDX[S_T2CFG], {11'h0, 2'(3 - k), 1'b0, 2'(k)}, ETP_OKAY);
            arm(4'd1, 4'd0, 1);
            pe(4'd1, {11'h0, ETP_GATE_DLY[k]});
            pe(4'd0, {5'h0, ETP_LATCH_W});
            pe(4'd3, {11'h0, ETP_GATE_DLY[k]}
                + {11'h0, ETP_GATE_DLY[3 - k]});
            drain();
        end
        finish_test();
    end
endmodule
`default_nettype wire
